/* core/ps_params.svh */
// constants of the programmable stage comparator
`ifndef PS_PARAMS_SVH
`define PS_PARAMS_SVH
`define PS_CLK_NS       5
`define PS_STEP_NS      5000000
`define PS_WIN_NS       20000000
`define PS_WIN_TICKS    (`PS_WIN_NS / `PS_STEP_NS)
`define PS_STEP_MS      5
`define PS_LIMIT        32'sd5000000
`define PS_DLY_MAX      19'd360000
`define PS_OP_DEF       19'd8
`define PS_REL_DEF      19'd12
`define PS_PICK_DEF     32'sd100
`define PS_HYST_DEF     20'd30000
`define PS_HYST_MAX     20'd500000
`define PS_HYST_DIV     1000000
`define PS_MULT_ONE     32'sh00010000
`define PS_RATIO_ONE    10000
`define PS_A_CTRL       8'h00
`define PS_A_OPDLY      8'h04
`define PS_A_RELDLY     8'h08
`define PS_A_BLKLIM     8'h0C
`define PS_A_CH0        8'h10
`define PS_A_STATUS     8'h40
`define PS_A_REMAIN     8'h44
`define PS_A_EXPECT     8'h48
`define PS_A_SCALED0    8'h50
`define PS_A_RATIO0     8'h60
`define PS_RESP_OK      2'b00
`define PS_RESP_ERR     2'b10
`endif

/* core/ps_pkg.sv */
// types of the programmable stage comparator
package ps_pkg;
   typedef enum logic [2:0] {
      MODE_OVER, MODE_OVER_ABS, MODE_UNDER, MODE_UNDER_ABS,
      MODE_DREL_DIR, MODE_DREL_ABS, MODE_DVAL_DIR, MODE_DVAL_ABS
   } ps_mode_type;
   typedef enum logic [1:0] {
      ST_NORMAL  = 2'b00,
      ST_START   = 2'b01,
      ST_TRIP    = 2'b11,
      ST_BLOCKED = 2'b10
   } ps_cond_type;
endpackage : ps_pkg

/* core/ps_stage.sv */
// programmable stage: three scaled comparators, timing and AXI4-Lite registers
`timescale 1ns/1ps
`include "ps_params.svh"
module ps_stage #(
   parameter int TICK_CYC = `PS_STEP_NS / `PS_CLK_NS
) (
   // clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // measurements and blocking
   input  wire logic signed [31:0] measured_value_one,
   input  wire logic signed [31:0] measured_value_two,
   input  wire logic signed [31:0] measured_value_three,
   input  wire logic               block_in,
   // stage outputs
   output logic                    start,
   output logic                    trip,
   output logic                    blocked,
   output ps_pkg::ps_cond_type     condition,
   // axi4-lite slave
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [7:0]         awaddr,
   input  wire logic               wvalid,
   output logic                    wready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   output logic                    bvalid,
   input  wire logic               bready,
   output logic [1:0]              bresp,
   input  wire logic               arvalid,
   output logic                    arready,
   input  wire logic [7:0]         araddr,
   output logic                    rvalid,
   input  wire logic               rready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp
);
   import ps_pkg::*;

   typedef struct packed {
      logic                     aw_got;
      logic                     w_got;
      logic [7:0]               waddr;
      logic [31:0]              wdat;
      logic [3:0]               wstb;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     rvalid;
      logic [31:0]              rdata;
      logic [1:0]               rresp;
      logic [2:0]               en;
      logic [2:0][2:0]          mode;
      logic [18:0]              op_dly;
      logic [18:0]              rel_dly;
      logic signed [31:0]       blk_lim;
      logic [2:0][31:0]         mult;
      logic [2:0][31:0]         pick;
      logic [2:0][19:0]         hyst;
      logic [31:0]              tick_cnt;
      logic [2:0][3:0][31:0]    hist;
      logic [2:0]               act;
      ps_cond_type              cond;
      logic [18:0]              op_cnt;
      logic [18:0]              rel_cnt;
      logic [2:0][31:0]         scaled;
      logic [3:0][31:0]         ratio;
      logic [31:0]              remain;
      logic [31:0]              expect_t;
   } ps_state_type;

   ps_state_type s, next_s;

   function automatic logic signed [31:0] ps_sat(input logic signed [63:0] v);
      if (v > 64'(`PS_LIMIT))
         return `PS_LIMIT;
      else if (v < -64'(`PS_LIMIT))
         return -`PS_LIMIT;
      return v[31:0];
   endfunction : ps_sat

   function automatic logic signed [63:0] ps_abs(input logic signed [63:0] v);
      return (v < 0) ? -v : v;
   endfunction : ps_abs

   // ratio in 0.0001 units; zero pick-up reads as full scale
   function automatic logic signed [31:0] ps_ratio(input logic signed [31:0] v, input logic signed [31:0] p);
      if (p == 0)
         return (v < 0) ? -`PS_LIMIT : `PS_LIMIT;
      return ps_sat((64'(v) * `PS_RATIO_ONE) / 64'(p));
   endfunction : ps_ratio

   // one comparator with hysteresis held while already active
   function automatic logic ps_cmp(input logic [2:0] m, input logic signed [31:0] v, input logic signed [31:0] old,
                                   input logic signed [31:0] p, input logic [19:0] hy,
                                   input logic signed [31:0] blk, input logic was);
      logic signed [63:0] h;
      logic signed [63:0] va;
      logic signed [63:0] d;
      logic signed [63:0] thr;
      h   = (ps_abs(64'(p)) * 64'(hy)) / `PS_HYST_DIV;
      va  = (m == MODE_OVER_ABS || m == MODE_UNDER_ABS) ? ps_abs(64'(v)) : 64'(v);
      d   = 64'(v) - 64'(old);
      thr = ps_abs(64'(p)) - (was ? h : 64'sd0);
      if (m == MODE_DREL_ABS || m == MODE_DVAL_ABS)
         d = ps_abs(d);
      else if (p < 0)
         d = -d;
      unique case (m)
         MODE_OVER, MODE_OVER_ABS:
            return was ? (va > 64'(p) - h) : (va > 64'(p));
         MODE_UNDER, MODE_UNDER_ABS:
            return (v >= blk) && (was ? (va < 64'(p) + h) : (va < 64'(p)));
         MODE_DREL_DIR, MODE_DREL_ABS:
            return (d > 0) && (d * `PS_HYST_DIV > thr * ps_abs(64'(old)));
         MODE_DVAL_DIR, MODE_DVAL_ABS:
            return d > thr;
      endcase
   endfunction : ps_cmp

   function automatic logic [31:0] ps_read(input ps_state_type st, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `PS_A_CTRL:   r = {19'h0, st.mode, 1'b0, st.en};
         `PS_A_OPDLY:  r = {13'h0, st.op_dly};
         `PS_A_RELDLY: r = {13'h0, st.rel_dly};
         `PS_A_BLKLIM: r = st.blk_lim;
         `PS_A_STATUS: r = {30'h0, st.cond};
         `PS_A_REMAIN: r = st.remain;
         `PS_A_EXPECT: r = st.expect_t;
         default: begin
            for (int i = 0; i < 3; i++) begin
               if (a == `PS_A_CH0 + 8'(16 * i))
                  r = st.mult[i];
               if (a == `PS_A_CH0 + 8'(16 * i + 4))
                  r = st.pick[i];
               if (a == `PS_A_CH0 + 8'(16 * i + 8))
                  r = {12'h0, st.hyst[i]};
               if (a == `PS_A_SCALED0 + 8'(4 * i))
                  r = st.scaled[i];
            end
            for (int i = 0; i < 4; i++)
               if (a == `PS_A_RATIO0 + 8'(4 * i))
                  r = st.ratio[i];
         end
      endcase
      return r;
   endfunction : ps_read

   function automatic logic ps_mapped(input logic [7:0] a);
      return (a[1:0] == 2'b00) && ((a < 8'h40 && (a < `PS_A_CH0 || a[3:2] != 2'b11))
             || (a >= `PS_A_STATUS && a <= `PS_A_EXPECT) || (a >= `PS_A_SCALED0 && a < 8'h5C)
             || (a >= `PS_A_RATIO0 && a < 8'h70));
   endfunction : ps_mapped

   logic signed [31:0] meas [3];
   logic               tick_now;
   logic               pk;
   logic [31:0]        wv;
   logic signed [31:0] deriv;
   assign meas[0]  = measured_value_one;
   assign meas[1]  = measured_value_two;
   assign meas[2]  = measured_value_three;
   assign tick_now = (s.tick_cnt == 32'(TICK_CYC - 1));

   always_comb begin
      next_s = s;
      pk     = 1'b0;
      deriv  = 32'sh0000_0000;
      wv     = 32'h0000_0000;
      // register bus: address and data in either order, response after both
      if (awvalid && awready) begin
         next_s.aw_got = 1'b1;
         next_s.waddr  = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_got = 1'b1;
         next_s.wdat  = wdata;
         next_s.wstb  = wstrb;
      end
      if (s.bvalid && bready)
         next_s.bvalid = 1'b0;
      if (s.aw_got && s.w_got) begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = ps_mapped(s.waddr) ? `PS_RESP_OK : `PS_RESP_ERR;
         wv = ps_read(s, s.waddr);
         for (int b = 0; b < 4; b++)
            if (s.wstb[b])
               wv[8*b +: 8] = s.wdat[8*b +: 8];
         unique case (s.waddr)
            `PS_A_CTRL: begin
               next_s.en   = wv[2:0];
               next_s.mode = wv[12:4];
            end
            `PS_A_OPDLY:  next_s.op_dly  = (wv > 32'(`PS_DLY_MAX)) ? `PS_DLY_MAX : wv[18:0];
            `PS_A_RELDLY: next_s.rel_dly = (wv > 32'(`PS_DLY_MAX)) ? `PS_DLY_MAX : wv[18:0];
            `PS_A_BLKLIM: next_s.blk_lim = wv;
            default:
               for (int i = 0; i < 3; i++) begin
                  if (s.waddr == `PS_A_CH0 + 8'(16 * i))
                     next_s.mult[i] = wv;
                  if (s.waddr == `PS_A_CH0 + 8'(16 * i + 4))
                     next_s.pick[i] = wv;
                  if (s.waddr == `PS_A_CH0 + 8'(16 * i + 8))
                     next_s.hyst[i] = (wv > 32'(`PS_HYST_MAX)) ? `PS_HYST_MAX : wv[19:0];
               end
         endcase
      end
      if (s.rvalid && rready)
         next_s.rvalid = 1'b0;
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rdata  = ps_read(s, araddr);
         next_s.rresp  = ps_mapped(araddr) ? `PS_RESP_OK : `PS_RESP_ERR;
      end
      // program cycle of one delay step
      next_s.tick_cnt = tick_now ? 32'h0 : s.tick_cnt + 32'h1;
      if (tick_now) begin
         for (int i = 0; i < 3; i++) begin
            next_s.scaled[i] = ps_sat((64'(meas[i]) * 64'(signed'(s.mult[i]))) >>> 16);
            next_s.hist[i]   = {s.hist[i][2:0], next_s.scaled[i]};
            next_s.act[i]    = s.en[i] && ps_cmp(s.mode[i], next_s.scaled[i], s.hist[i][`PS_WIN_TICKS - 1],
                                                 s.pick[i], s.hyst[i], s.blk_lim, s.act[i]);
            next_s.ratio[i]  = ps_ratio(next_s.scaled[i], s.pick[i]);
            if (s.en[i])
               deriv = ps_sat(64'(deriv) + 64'(signed'(next_s.scaled[i])));
         end
         next_s.ratio[3] = ps_ratio(deriv, s.pick[0]);
         pk = |next_s.act;
         unique case (s.cond)
            ST_NORMAL:
               if (pk) begin
                  next_s.cond   = block_in ? ST_BLOCKED : ST_START;
                  next_s.op_cnt = 19'h0;
               end
            ST_START, ST_TRIP:
               if (block_in && s.cond == ST_START) begin
                  next_s.cond = ST_BLOCKED;
               end else if (pk) begin
                  next_s.rel_cnt = 19'h0;
                  if (s.cond == ST_START) begin
                     next_s.op_cnt = s.op_cnt + 19'h1;
                     if (s.op_cnt + 19'h1 >= s.op_dly)
                        next_s.cond = ST_TRIP;
                  end
               end else begin
                  next_s.rel_cnt = s.rel_cnt + 19'h1;
                  if (s.rel_cnt + 19'h1 >= s.rel_dly)
                     next_s.cond = ST_NORMAL;
               end
            ST_BLOCKED:
               if (!block_in) begin
                  next_s.cond   = pk ? ST_START : ST_NORMAL;
                  next_s.op_cnt = 19'h0;
               end
         endcase
         // delay rewritten below the count mid-start must not wrap the remaining time
         next_s.remain   = (next_s.cond == ST_START && next_s.op_cnt < next_s.op_dly)
                           ? 32'(next_s.op_dly - next_s.op_cnt) * `PS_STEP_MS : 32'h0;
         next_s.expect_t = pk ? 32'(s.op_dly) * `PS_STEP_MS : 32'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s          <= '0;
         s.op_dly   <= `PS_OP_DEF;
         s.rel_dly  <= `PS_REL_DEF;
         s.mult     <= {3{`PS_MULT_ONE}};
         s.pick     <= {3{`PS_PICK_DEF}};
         s.hyst     <= {3{`PS_HYST_DEF}};
         s.cond     <= ST_NORMAL;
      end else begin
         s <= next_s;
      end
   end

   assign awready   = !s.aw_got && !s.bvalid;
   assign wready    = !s.w_got && !s.bvalid;
   assign bvalid    = s.bvalid;
   assign bresp     = s.bresp;
   assign arready   = !s.rvalid;
   assign rvalid    = s.rvalid;
   assign rdata     = s.rdata;
   assign rresp     = s.rresp;
   assign condition = s.cond;
   assign start     = (s.cond == ST_START) || (s.cond == ST_TRIP);
   assign trip      = (s.cond == ST_TRIP);
   assign blocked   = (s.cond == ST_BLOCKED);

   default clocking ps_cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   trip_has_start_a: assert property (trip |-> start && !blocked) else $error("trip without start");
   trip_after_delay_a: assert property ($rose(trip) |-> $past(s.cond) == ST_START
      && $past(s.op_cnt) + 19'h1 >= $past(s.op_dly)) else $error("trip before delay");
   blocked_quiet_a: assert property (blocked |-> !start && !trip) else $error("blocked with start");
   start_on_pick_a: assert property (tick_now && s.cond == ST_NORMAL && |next_s.act && !block_in
      |=> start && !trip) else $error("no start at pick-up");
   scaled_range_a: assert property (tick_now |=> signed'(s.scaled[0]) <= `PS_LIMIT
      && signed'(s.scaled[0]) >= -`PS_LIMIT) else $error("scaled out of range");
   ratio_range_a: assert property (tick_now |=> signed'(s.ratio[3]) <= `PS_LIMIT
      && signed'(s.ratio[3]) >= -`PS_LIMIT) else $error("ratio out of range");
   remain_range_a: assert property (s.remain <= 32'(s.op_dly) * `PS_STEP_MS
      && (s.cond != ST_START -> s.remain == 32'h0)) else $error("remaining time wrong");
   expect_normal_a: assert property (s.cond == ST_NORMAL && $past(s.cond) == ST_NORMAL && $stable(s.cond)
      && !tick_now ##1 s.cond == ST_NORMAL |-> s.expect_t == 32'h0 || $past(|next_s.act))
      else $error("expected time in normal");
   under_block_a: assert property (tick_now && s.en[0] && s.mode[0] == MODE_UNDER
      && signed'(next_s.scaled[0]) < s.blk_lim |=> !s.act[0]) else $error("under not suppressed");
   mode_default_a: assert property ($rose(aresetn) |-> s.mode == 9'h0 && s.op_dly == `PS_OP_DEF)
      else $error("bad defaults");
   resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");

   start_seen_c: cover property ($rose(start));
   trip_seen_c: cover property ($rose(trip));
   blocked_seen_c: cover property ($rose(blocked));
   release_seen_c: cover property ($fell(trip) && !start);
endmodule : ps_stage

/* verif/ps_meas_src.sv */
// measurement source model feeding the three stage channels
`timescale 1ns/1ps
module ps_meas_src (
   // clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // values requested by the bench
   input  wire logic signed [31:0] want_one,
   input  wire logic signed [31:0] want_two,
   input  wire logic signed [31:0] want_three,
   // measurements towards the stage
   output logic signed [31:0]      measured_value_one,
   output logic signed [31:0]      measured_value_two,
   output logic signed [31:0]      measured_value_three
);
   // the front end only publishes new samples on its own edge, never mid-cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         measured_value_one   <= '0;
         measured_value_two   <= '0;
         measured_value_three <= '0;
      end else begin
         measured_value_one   <= want_one;
         measured_value_two   <= want_two;
         measured_value_three <= want_three;
      end
   end
endmodule : ps_meas_src

/* verif/ps_stage_tb_top.sv */
// self-checking bench of the programmable stage comparator
`timescale 1ns/1ps
`include "ps_params.svh"
module ps_stage_tb_top;
   import ps_pkg::*;
   localparam int TICK  = 8;
   localparam int LIMIT = 30000;
   logic               aclk = 1'b0;
   logic               aresetn = 1'b0;
   logic               block_in = 1'b0;
   logic signed [31:0] want_one = '0, want_two = '0, want_three = '0;
   logic signed [31:0] mv1, mv2, mv3, v;
   logic               start, trip, blocked;
   ps_cond_type        condition;
   logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic               awready, wready, bvalid, arready, rvalid;
   logic [7:0]         awaddr = '0, araddr = '0;
   logic [31:0]        wdata = '0, rdata;
   logic [3:0]         wstrb = 4'hF;
   logic [1:0]         bresp, rresp;
   logic [1:0]         bq[$];
   logic [33:0]        rq[$];
   int                 fail_count = 0, n_compared = 0, cyc = 0, seed = 98, t0, i;
   int m_mode[10] = '{0, 0, 1, 2, 2, 3, 4, 5, 6, 7};
   int m_pick[10] = '{100, 100, 100, 100, 100, 100, -100, 100, 100, 100};
   int m_v0[10]   = '{0, 0, 0, 500, 500, 500, 1000, 1000, 0, 0};
   int m_v1[10]   = '{500, -500, -500, 50, -2000, -50, 500, 1500, -1000, -1000};
   bit m_up[10]   = '{1, 0, 1, 1, 0, 1, 1, 1, 0, 1};

   always #2.5 aclk = ~aclk;

   ps_meas_src i_meas (.aclk(aclk), .aresetn(aresetn), .want_one(want_one), .want_two(want_two),
      .want_three(want_three), .measured_value_one(mv1), .measured_value_two(mv2),
      .measured_value_three(mv3));

   ps_stage #(.TICK_CYC(TICK)) i_dut (.aclk(aclk), .aresetn(aresetn), .measured_value_one(mv1),
      .measured_value_two(mv2), .measured_value_three(mv3), .block_in(block_in), .start(start),
      .trip(trip), .blocked(blocked), .condition(condition), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // stage outputs looked at mid-cycle, away from the edge that moves them
   task automatic outs(input ps_cond_type c);
      @(negedge aclk);
      chk(34'({condition, blocked, start, trip}),
          34'({c, c == ST_BLOCKED, c == ST_START || c == ST_TRIP, c == ST_TRIP}));
      @(posedge aclk);
   endtask : outs

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // watcher: each answer taken is matched with the oldest note
   always @(posedge aclk) begin
      cyc++;
      if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
      if (cyc == LIMIT) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // handshakes are judged at the falling edge, where everything has settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `PS_RESP_OK);
      logic ta, tw, tb;
      bq.push_back(er);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      bready  <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `PS_RESP_OK);
      logic ta, tr;
      rq.push_back({er, d});
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask : rd

   task automatic put(input logic signed [31:0] x);
      @(posedge aclk);
      want_one <= x;
   endtask : put

   task automatic ticks(input int n);
      repeat (n * TICK) @(posedge aclk);
   endtask : ticks

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`PS_A_CTRL, 32'h0);
      rd(`PS_A_OPDLY, 32'h8);
      rd(`PS_A_RELDLY, 32'hC);
      rd(`PS_A_CH0, 32'h00010000);
      rd(`PS_A_CH0 + 8'h04, 32'h64);
      rd(`PS_A_CH0 + 8'h08, 32'h7530);
      rd(`PS_A_STATUS, 32'(ST_NORMAL));
      rd(8'hFC, 32'h0, `PS_RESP_ERR);
      rd(`PS_A_CH0 + 8'h0C, 32'h0, `PS_RESP_ERR);
      wr(8'hFC, 32'h5A, `PS_RESP_ERR);
      wr(`PS_A_CH0 + 8'h08, 32'd600000);
      rd(`PS_A_CH0 + 8'h08, 32'd500000);
      wr(`PS_A_OPDLY, 32'd400000);
      rd(`PS_A_OPDLY, 32'd360000);
      wr(`PS_A_CH0 + 8'h04, -32'sd250);
      rd(`PS_A_CH0 + 8'h04, -32'sd250);
      wr(`PS_A_CH0 + 8'h08, 32'h0);
      wr(`PS_A_OPDLY, 32'h8);
      wstrb <= 4'h1;
      wr(`PS_A_RELDLY, 32'hAABBCC05);
      wstrb <= 4'hF;
      rd(`PS_A_RELDLY, 32'h5);
      wr(`PS_A_RELDLY, 32'h1);
      wr(`PS_A_BLKLIM, -32'sd1000);
      $display("test registers done");
      // every comparator mode except MODE_DVAL_DIR picking once; quiet cases only for MODE_OVER, MODE_UNDER and MODE_DVAL_DIR
      for (i = 0; i < 10; i++) begin
         wr(`PS_A_CH0 + 8'h04, m_pick[i]);
         wr(`PS_A_CTRL, 32'h1 | 32'(m_mode[i] << 4));
         put(m_v0[i]);
         ticks(8);
         rd(`PS_A_STATUS, 32'(ST_NORMAL));
         put(m_v1[i]);
         ticks(2);
         rd(`PS_A_STATUS, m_up[i] ? 32'(ST_START) : 32'(ST_NORMAL));
      end
      $display("test modes done");
      wr(`PS_A_CTRL, 32'h7);
      wr(`PS_A_CH0 + 8'h04, 32'h64);
      wr(`PS_A_CH0, 32'h00020000);
      want_two   <= 32'sd700;
      want_three <= -32'sd300;
      put(32'sd3000000);
      ticks(2);
      rd(`PS_A_SCALED0, 32'd5000000);
      rd(`PS_A_SCALED0 + 8'h04, 32'd700);
      rd(`PS_A_SCALED0 + 8'h08, -32'sd300);
      put(32'sd1000);
      ticks(2);
      rd(`PS_A_SCALED0, 32'd2000);
      rd(`PS_A_RATIO0, 32'd200000);
      put(-32'sd3000000);
      ticks(2);
      rd(`PS_A_SCALED0, -32'sd5000000);
      wr(`PS_A_CH0, 32'h00010000);
      for (i = 0; i < 4; i++) begin
         v = $random(seed) % 2000000;
         put(v);
         ticks(2);
         rd(`PS_A_SCALED0, v);
      end
      $display("test scaling done");
      want_two   <= '0;
      want_three <= '0;
      put(32'sd0);
      wr(`PS_A_CTRL, 32'h1);
      wr(`PS_A_OPDLY, 32'h4);
      wr(`PS_A_RELDLY, 32'h3);
      ticks(6);
      put(32'sd500);
      while (start !== 1'b1) @(negedge aclk);
      t0 = cyc;
      outs(ST_START);
      rd(`PS_A_REMAIN, 32'd20);
      rd(`PS_A_EXPECT, 32'd20);
      while (trip !== 1'b1) @(negedge aclk);
      chk(34'(cyc - t0), 34'(4 * TICK));
      put(32'sd0);
      ticks(1);
      rd(`PS_A_STATUS, 32'(ST_TRIP));
      outs(ST_TRIP);
      ticks(4);
      rd(`PS_A_STATUS, 32'(ST_NORMAL));
      outs(ST_NORMAL);
      $display("test timing done");
      block_in <= 1'b1;
      put(32'sd500);
      ticks(2);
      rd(`PS_A_STATUS, 32'(ST_BLOCKED));
      outs(ST_BLOCKED);
      block_in <= 1'b0;
      ticks(2);
      rd(`PS_A_STATUS, 32'(ST_START));
      outs(ST_START);
      block_in <= 1'b1;
      ticks(2);
      rd(`PS_A_STATUS, 32'(ST_BLOCKED));
      outs(ST_BLOCKED);
      $display("test blocking done");
      tally_and_finish();
   end
endmodule : ps_stage_tb_top
